// [gptm_pkg.sv]
`default_nettype none

// ============================================================
// shared constants and types
package gptm_pkg;

  // ============================================================
  // clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  // cycles in one millisecond, the unit every resolution is built from
  localparam int MS_CYC = CLK_HZ / MS_PER_S;

  // ============================================================
  // register offsets on the plain register port
  localparam int ADDR_W = 5;
  localparam logic [4:0] A_OUT0 = 5'h00;
  localparam logic [4:0] A_OUT1 = 5'h04;
  localparam logic [4:0] A_IN0 = 5'h08;
  localparam logic [4:0] A_IN1 = 5'h0C;
  localparam logic [4:0] A_STAT = 5'h10;

  // ============================================================
  // command word layout
  localparam int WORD_W = 16;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 10;
  localparam int ERR_BIT = 15;
  localparam int REL_BIT = 9;
  localparam int SYS_HI = 9;
  localparam int MCFG_HI = 7;

  // command codes in bits 15..10
  localparam logic [5:0] C_READ = 6'h00;
  localparam logic [5:0] C_DEFAULT = 6'h0A;
  localparam logic [5:0] C_SYSSET = 6'h0C;
  localparam logic [5:0] C_TIMEMEAS = 6'h06;
  localparam logic [5:0] C_PRESET_INIT = 6'h10;

  // field values
  localparam logic [1:0] IN_CFG_LOGIC = 2'h3;
  localparam logic [3:0] REL_NONE = 4'h0;
  localparam logic [3:0] REL_GE = 4'h1;

  // resolution code to milliseconds: 00 1 ms, 01 2 ms, 10 10 ms, 11 100 ms
  localparam int RES_W = 7;
  localparam logic [6:0] RES_MS [4] = '{7'h01, 7'h02, 7'h0A, 7'h64};

  // status register bit positions
  localparam int STAT_REL = 0;
  localparam int STAT_SRC = 1;
  localparam int STAT_MODE = 2;
  localparam int STAT_OUT = 3;

  // ============================================================
  // types
  // system settings: bits 9..0 of the settings word
  typedef struct packed {
    logic [1:0] in_cfg;
    logic [3:0] logic_fn;
    logic bus_rst_resp;
    logic [2:0] pulse_len;
  } gptm_sys_s;

  // time measurement settings: bits 7..0 of the mode word
  typedef struct packed {
    logic [1:0] res;
    logic out_en;
    logic ptype;
    logic [3:0] rel;
  } gptm_mcfg_s;

  typedef enum {
    GPTM_MODE_NONE,
    GPTM_MODE_TIME
  } gptm_mode_e;

  localparam gptm_sys_s SYS_DEFAULT = '0;
  localparam gptm_mcfg_s MCFG_DEFAULT = '0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage

`default_nettype wire

// [gptm_in_sync.sv]
`default_nettype none

// ============================================================
// three-stage pin synchroniser with agreement filter
module gptm_in_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous pins and their clean copies
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  if (W < 1) begin : g_chk
    $error("gptm_in_sync needs at least one bit");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r, s2_r, s3_r, q_r;
    logic q_nxt;

    // output follows only once stage two and three agree; stage one feeds stage two alone
    always_comb begin
      q_nxt = q_r;
      if (s2_r == s3_r) begin
        q_nxt = s3_r;
      end
    end

    // registers of the chain
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        q_r <= 1'b0;
      end else begin
        s1_r <= din[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        q_r <= q_nxt;
      end
    end

    assign dout[i] = q_r;
  end

endmodule

`default_nettype wire

// [gptm_top.sv]
// Strobed register access and the placing of the registers are this design's own decisions.
`default_nettype none

// ============================================================
// gated pulse time measurement counter
//
// Operation
// - Word 2800 hex restores default parameterisation; second word ignored.
// - Command bits 15..10 = 001100 decode as system settings.
// - Input configuration 11 in bits 9..8 enables source-gate logic combination.
// - Logic field 1110 in bits 7..4 selects OR of source and gate.
// - Settings bit 3 picks bus reset reaction; 0 means no action.
// - Settings bits 2..0 hold output pulse length; 000 is 10 ms. The design stores this field but never uses it.
// - Word 4000 hex presets the initial value taken from the second word.
// - Command bits 15..10 = 000110 decode as time measurement mode.
// - Resolution field bits 7..6 = 01 selects a 2 ms time base.
// - Type bit 4 = 1 measures pulse length of the effective source.
// - Relation code 0001 is true when count is at least the initial value.
// - Relation result shows in reply bit 9; output enable 0 leaves output low.
// - Read command 0000 hex returns the 16-bit count in reply word two.
// - Accepted command word and parameter word are mirrored into the replies, except for the read command.
// - An identical repeated preset is ignored until another code intervenes.
// - Reply bit 15 flags errors such as a read before any mode is set.
module gptm_top #(
  parameter int MS_CYC = gptm_pkg::MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [gptm_pkg::ADDR_W-1:0] addr,
  input wire logic [gptm_pkg::WORD_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [gptm_pkg::WORD_W-1:0] rdata,
  // bus cycle events
  input wire logic bus_cycle,
  input wire logic bus_reset,
  // field inputs
  input wire logic src_pin,
  input wire logic gate_pin,
  // relation output level
  output logic rel_out
);

  if (MS_CYC < 2) begin : g_chk
    $error("gptm_top needs at least two clocks per millisecond");
  end

  localparam int MSW = $clog2(MS_CYC);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYC - 1);

  // ============================================================
  // pin conditioning
  logic [1:0] pins_q;
  logic src_q, gate_q;

  gptm_in_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din({src_pin, gate_pin}),
    .dout(pins_q)
  );

  assign src_q = pins_q[1];
  assign gate_q = pins_q[0];

  // ============================================================
  // command group state
  logic [15:0] out0_r, out0_nxt;
  logic [15:0] out1_r, out1_nxt;
  logic [15:0] prev_r, prev_nxt;
  logic [15:0] in0_r, in0_nxt;
  logic [15:0] in1_r, in1_nxt;
  logic [15:0] init_r, init_nxt;
  logic rd_act_r, rd_act_nxt;
  gptm_pkg::gptm_sys_s sys_r, sys_nxt;
  gptm_pkg::gptm_mcfg_s mcfg_r, mcfg_nxt;
  gptm_pkg::gptm_mode_e mode_r, mode_nxt;
  logic clr_cnt;

  // ============================================================
  // measurement group state
  logic [MSW-1:0] ms_r, ms_nxt;
  logic [6:0] res_r, res_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic eff_d_r, eff_d_nxt;
  logic rel_r, rel_nxt;
  logic out_r, out_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic eff_src, ms_tick, res_tick, measuring;

  // ============================================================
  // command decode and reply words
  // acting only on a change of word one makes a repeated preset harmless
  always_comb begin
    out0_nxt = out0_r;
    out1_nxt = out1_r;
    prev_nxt = prev_r;
    in0_nxt = in0_r;
    in1_nxt = in1_r;
    init_nxt = init_r;
    rd_act_nxt = rd_act_r;
    sys_nxt = sys_r;
    mcfg_nxt = mcfg_r;
    mode_nxt = mode_r;
    clr_cnt = 1'b0;
    // software side of the process data words
    if (wr && addr == gptm_pkg::A_OUT0) begin
      out0_nxt = wdata;
    end
    if (wr && addr == gptm_pkg::A_OUT1) begin
      out1_nxt = wdata;
    end
    // the running read keeps count and relation fresh between bus cycles
    if (rd_act_r) begin
      in1_nxt = cnt_r;
      in0_nxt[gptm_pkg::REL_BIT] = rel_r;
    end
    if (bus_cycle) begin
      prev_nxt = out0_r;
      if (out0_r != prev_r) begin
        rd_act_nxt = 1'b0;
        in0_nxt = out0_r;
        in1_nxt = out1_r;
        case (out0_r[gptm_pkg::CMD_HI:gptm_pkg::CMD_LO])
          gptm_pkg::C_DEFAULT: begin
            sys_nxt = gptm_pkg::SYS_DEFAULT;
            mcfg_nxt = gptm_pkg::MCFG_DEFAULT;
            mode_nxt = gptm_pkg::GPTM_MODE_NONE;
            init_nxt = gptm_pkg::WORD_RESET;
            clr_cnt = 1'b1;
          end
          gptm_pkg::C_SYSSET: begin
            sys_nxt = out0_r[gptm_pkg::SYS_HI:0];
          end
          gptm_pkg::C_PRESET_INIT: begin
            init_nxt = out1_r;
          end
          gptm_pkg::C_TIMEMEAS: begin
            mcfg_nxt = out0_r[gptm_pkg::MCFG_HI:0];
            mode_nxt = gptm_pkg::GPTM_MODE_TIME;
            clr_cnt = 1'b1;
          end
          gptm_pkg::C_READ: begin
            // reply carries status, not a mirror: host compares only the code bits
            rd_act_nxt = 1'b1;
            in0_nxt = gptm_pkg::WORD_RESET;
            in0_nxt[gptm_pkg::ERR_BIT] = (mode_r == gptm_pkg::GPTM_MODE_NONE);
            in0_nxt[gptm_pkg::REL_BIT] = rel_r;
            in1_nxt = cnt_r;
          end
          default: begin
            in0_nxt[gptm_pkg::ERR_BIT] = 1'b1;
          end
        endcase
      end
    end
    // reaction to a bus reset is chosen by the settings word
    if (bus_reset && sys_r.bus_rst_resp) begin
      mcfg_nxt = gptm_pkg::MCFG_DEFAULT;
      mode_nxt = gptm_pkg::GPTM_MODE_NONE;
      init_nxt = gptm_pkg::WORD_RESET;
      rd_act_nxt = 1'b0;
      clr_cnt = 1'b1;
    end
  end

  // command group registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out0_r <= gptm_pkg::WORD_RESET;
      out1_r <= gptm_pkg::WORD_RESET;
      prev_r <= gptm_pkg::WORD_RESET;
      in0_r <= gptm_pkg::WORD_RESET;
      in1_r <= gptm_pkg::WORD_RESET;
      init_r <= gptm_pkg::WORD_RESET;
      rd_act_r <= 1'b0;
      sys_r <= gptm_pkg::SYS_DEFAULT;
      mcfg_r <= gptm_pkg::MCFG_DEFAULT;
      mode_r <= gptm_pkg::GPTM_MODE_NONE;
    end else begin
      out0_r <= out0_nxt;
      out1_r <= out1_nxt;
      prev_r <= prev_nxt;
      in0_r <= in0_nxt;
      in1_r <= in1_nxt;
      init_r <= init_nxt;
      rd_act_r <= rd_act_nxt;
      sys_r <= sys_nxt;
      mcfg_r <= mcfg_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ============================================================
  // source-gate logic stage
  // the function field is a truth table indexed by {source, gate}, so 1110 is OR
  always_comb begin
    eff_src = src_q;
    if (sys_r.in_cfg == gptm_pkg::IN_CFG_LOGIC) begin
      eff_src = sys_r.logic_fn[{src_q, gate_q}];
    end
  end

  // millisecond and resolution enables
  assign ms_tick = (ms_r == MS_LAST);
  assign res_tick = ms_tick && (res_r == gptm_pkg::RES_MS[mcfg_r.res] - 7'h01);
  assign measuring = (mode_r == gptm_pkg::GPTM_MODE_TIME) && mcfg_r.ptype;

  // ============================================================
  // pulse length counter and relation
  // a rising edge restarts both the count and the time base, so the first
  // step lands a full resolution period after the edge
  always_comb begin
    ms_nxt = ms_tick ? '0 : ms_r + MSW'(1);
    res_nxt = res_r;
    if (ms_tick) begin
      res_nxt = res_tick ? 7'h00 : res_r + 7'h01;
    end
    cnt_nxt = cnt_r;
    eff_d_nxt = eff_src;
    if (clr_cnt) begin
      cnt_nxt = gptm_pkg::WORD_RESET;
      ms_nxt = '0;
      res_nxt = 7'h00;
    end else if (measuring) begin
      if (eff_src && !eff_d_r) begin
        cnt_nxt = gptm_pkg::WORD_RESET;
        ms_nxt = '0;
        res_nxt = 7'h00;
      end else if (eff_src && res_tick && cnt_r != 16'hFFFF) begin
        cnt_nxt = cnt_r + 16'h0001; // saturates rather than wrapping
      end
    end
    // relation evaluated on the live count; unknown codes give false
    unique case (mcfg_r.rel)
      gptm_pkg::REL_GE: rel_nxt = measuring && (cnt_r >= init_r);
      default: rel_nxt = 1'b0;
    endcase
    out_nxt = rel_r && mcfg_r.out_en;
  end

  // measurement group registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ms_r <= '0;
      res_r <= 7'h00;
      cnt_r <= gptm_pkg::WORD_RESET;
      eff_d_r <= 1'b0;
      rel_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      ms_r <= ms_nxt;
      res_r <= res_nxt;
      cnt_r <= cnt_nxt;
      eff_d_r <= eff_d_nxt;
      rel_r <= rel_nxt;
      out_r <= out_nxt;
    end
  end

  // ============================================================
  // register read port, data valid one cycle after the strobe
  always_comb begin
    rdata_nxt = gptm_pkg::WORD_RESET;
    if (rd) begin
      case (addr)
        gptm_pkg::A_OUT0: rdata_nxt = out0_r;
        gptm_pkg::A_OUT1: rdata_nxt = out1_r;
        gptm_pkg::A_IN0: rdata_nxt = in0_r;
        gptm_pkg::A_IN1: rdata_nxt = in1_r;
        gptm_pkg::A_STAT: begin
          rdata_nxt[gptm_pkg::STAT_REL] = rel_r;
          rdata_nxt[gptm_pkg::STAT_SRC] = eff_src;
          rdata_nxt[gptm_pkg::STAT_MODE] = (mode_r == gptm_pkg::GPTM_MODE_TIME);
          rdata_nxt[gptm_pkg::STAT_OUT] = out_r;
        end
        default: rdata_nxt = gptm_pkg::WORD_RESET; // unmapped reads zero
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= gptm_pkg::WORD_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rel_out = out_r;

endmodule

`default_nettype wire

// [gptm_sva.sv]
`default_nettype none

// ============================================================
// port checker
module gptm_sva #(
  parameter int MS_CYC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [gptm_pkg::ADDR_W-1:0] addr,
  input wire logic [gptm_pkg::WORD_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [gptm_pkg::WORD_W-1:0] rdata,
  // events, pins, output
  input wire logic bus_cycle,
  input wire logic bus_reset,
  input wire logic src_pin,
  input wire logic gate_pin,
  input wire logic rel_out
);
  logic [15:0] o0_r, o1_r, pv_r, lw_r, lp_r;
  logic [9:0] sys_r;
  logic [1:0] sg_r;
  logic [3:0] st_r;
  logic [5:0] oc, lc;
  logic tm_r, oe_r, ac_r, act, rq, kn;
  // reads on an event edge are skipped: the replies move at that same edge
  assign oc = o0_r[15:10];
  assign lc = lw_r[15:10];
  assign act = bus_cycle && !bus_reset && o0_r != pv_r;
  assign rq = rd && !bus_cycle && !bus_reset;
  assign kn = lc inside {gptm_pkg::C_READ, gptm_pkg::C_DEFAULT, gptm_pkg::C_SYSSET, gptm_pkg::C_TIMEMEAS,
    gptm_pkg::C_PRESET_INIT};

  // shadow of the command words and of what the counter should have taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      o0_r <= '0;
      o1_r <= '0;
      pv_r <= '0;
      lw_r <= '0;
      lp_r <= '0;
      sys_r <= '0;
      sg_r <= '0;
      st_r <= '0;
      tm_r <= 1'b0;
      oe_r <= 1'b0;
      ac_r <= 1'b0;
    end else begin
      if (wr && addr == gptm_pkg::A_OUT0) o0_r <= wdata;
      if (wr && addr == gptm_pkg::A_OUT1) o1_r <= wdata;
      if (bus_cycle) pv_r <= o0_r;
      if (act) begin
        ac_r <= 1'b1;
        lw_r <= o0_r;
        lp_r <= o1_r;
      end
      if (act && oc == gptm_pkg::C_DEFAULT) sys_r <= '0;
      if (act && oc == gptm_pkg::C_SYSSET) sys_r <= o0_r[9:0];
      if ((act && oc == gptm_pkg::C_DEFAULT) || (bus_reset && sys_r[3])) begin
        tm_r <= 1'b0;
        oe_r <= 1'b0;
      end
      if (act && oc == gptm_pkg::C_TIMEMEAS) begin
        tm_r <= 1'b1;
        oe_r <= o0_r[5];
      end
      sg_r <= {src_pin, gate_pin};
      st_r <= ({src_pin, gate_pin} != sg_r) ? 4'h0 : st_r + {3'h0, st_r != 4'hF};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ============================================================
  // replies and status
  a_in0_mirror: assert property (
    rq && ac_r && addr == gptm_pkg::A_IN0 && kn && lc != gptm_pkg::C_READ |=> rdata == lw_r)
    else $error("reply word 1 not mirrored");
  a_in1_param: assert property (
    rq && ac_r && addr == gptm_pkg::A_IN1 && lc != gptm_pkg::C_READ |=> rdata == lp_r)
    else $error("reply word 2 not mirrored");
  a_unk_error: assert property (
    rq && ac_r && addr == gptm_pkg::A_IN0 && !kn |=> rdata == (lw_r | 16'h8000))
    else $error("unknown code without error flag");
  a_read_error: assert property (
    rq && ac_r && addr == gptm_pkg::A_IN0 && lc == gptm_pkg::C_READ |=> (rdata & 16'hFDFF) == {!tm_r, 15'h0000})
    else $error("read reply flag wrong");
  a_mode_flag: assert property (
    rq && addr == gptm_pkg::A_STAT |=> rdata[gptm_pkg::STAT_MODE] == tm_r)
    else $error("mode flag wrong");
  a_src_or: assert property (
    rq && addr == gptm_pkg::A_STAT && st_r == 4'hF && sys_r[9:4] == 6'h3E
    |=> rdata[gptm_pkg::STAT_SRC] == $past(src_pin || gate_pin))
    else $error("combined source wrong");
  a_src_plain: assert property (
    rq && addr == gptm_pkg::A_STAT && st_r == 4'hF && sys_r[9:8] != 2'h3
    |=> rdata[gptm_pkg::STAT_SRC] == $past(src_pin))
    else $error("plain source wrong");
  a_out_unused: assert property (
    !oe_r && !$past(oe_r) |-> !rel_out)
    else $error("output driven while unused");

  c_meas: cover property (rq && ac_r && lc == gptm_pkg::C_READ && tm_r);
  c_unknown: cover property (rq && ac_r && !kn);
  c_bus_reset: cover property (bus_reset && tm_r);
endmodule

bind gptm_top gptm_sva #(.MS_CYC(MS_CYC)) i_sva (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .bus_cycle(bus_cycle), .bus_reset(bus_reset), .src_pin(src_pin), .gate_pin(gate_pin),
  .rel_out(rel_out));

`default_nettype wire

// [gptm_fb_model.sv]
`default_nettype none

// ============================================================
// fieldbus controller: bus cycle and bus reset events
module gptm_fb_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench control
  input wire logic slow,
  input wire logic rst_req,
  // events toward the counter
  output logic bus_cycle,
  output logic bus_reset
);
  int gap;
  // random gaps of 2 to 5 cycles, or a fixed gap of 12 when slow is set; a bus reset never shares an edge with a cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap <= 2;
      bus_cycle <= 1'b0;
      bus_reset <= 1'b0;
    end else begin
      bus_cycle <= gap == 0;
      bus_reset <= gap != 0 && rst_req;
      gap <= (gap != 0) ? gap - 1 : (slow ? 12 : 2 + int'($urandom_range(3)));
    end
  end
endmodule

`default_nettype wire

// [tb_top.sv]
`default_nettype none

// ============================================================
// bench for the time measurement counter
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 4;
  // clocks per count at the 2 ms resolution
  localparam int TB = 2 * MSC;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic src = 1'b0;
  logic gate = 1'b0;
  logic slow = 1'b0;
  logic rreq = 1'b0;
  logic [4:0] addr = '0;
  logic [15:0] wdata = '0;
  logic [15:0] rdata, r, w, v;
  logic bus_cycle, bus_reset, rel_out;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  gptm_top #(.MS_CYC(MSC)) i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bus_cycle(bus_cycle), .bus_reset(bus_reset), .src_pin(src), .gate_pin(gate), .rel_out(rel_out));
  gptm_fb_model i_fb (.clk(clk), .nrst(nrst), .slow(slow), .rst_req(rreq), .bus_cycle(bus_cycle),
    .bus_reset(bus_reset));

  // clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end

  // ============================================================
  // tasks and expectations
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so they are taken at the edge that ends that cycle
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // parameter word first, then command, then poll the reply
  task automatic cmd(input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] e0, input logic [15:0] m);
    logic [15:0] q;
    wr_reg(gptm_pkg::A_OUT1, c1);
    wr_reg(gptm_pkg::A_OUT0, c0);
    q = ~e0;
    for (int i = 0; i < 40 && (q & m) !== (e0 & m); i++) rd_reg(gptm_pkg::A_IN0, q);
    chk("reply word 1", e0 & m, q & m);
  endtask
  // one bus reset event; the request may stretch into a second event, which is harmless
  task automatic bus_rst();
    @(posedge clk);
    rreq <= 1'b1;
    for (int i = 0; i < 40 && bus_reset !== 1'b1; i++) @(posedge clk);
    rreq <= 1'b0;
  endtask
  function automatic logic [15:0] exp_in0(input logic [15:0] c, input logic tm, input logic rel);
    case (c[15:10])
      gptm_pkg::C_READ: exp_in0 = {~tm, 5'h00, rel, 9'h000};
      gptm_pkg::C_DEFAULT, gptm_pkg::C_SYSSET, gptm_pkg::C_TIMEMEAS, gptm_pkg::C_PRESET_INIT: exp_in0 = c;
      default: exp_in0 = c | 16'h8000;
    endcase
  endfunction
  // settle time covers the pin synchroniser
  task automatic src_check(input logic lg);
    for (int j = 0; j < 4; j++) begin
      src <= j[1];
      gate <= j[0];
      repeat (20) @(posedge clk);
      rd_reg(gptm_pkg::A_STAT, r);
      chk("effective source", {15'h0000, lg ? j[1] | j[0] : j[1]}, {15'h0000, r[gptm_pkg::STAT_SRC]});
    end
    src <= 1'b0;
    gate <= 1'b0;
  endtask
  // a pulse on source or gate; counts sampled while it is still high
  task automatic pulse(input int k, input logic on_gate);
    repeat (20) @(posedge clk);
    if (on_gate) gate <= 1'b1;
    else src <= 1'b1;
    repeat (k * TB + 6) @(posedge clk);
    rd_reg(gptm_pkg::A_IN1, r);
    chk("count", 16'((k * TB + 4) / TB), r);
    rd_reg(gptm_pkg::A_IN0, r);
    chk("read reply", exp_in0(16'h0000, 1'b1, k >= 3), r);
    chk("relation output", 16'h0000, {15'h0000, rel_out});
    src <= 1'b0;
    gate <= 1'b0;
  endtask

  // ============================================================
  // main sequence
  initial begin
    v = $urandom(32'hcf0ba710);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    cmd(16'h2800, 16'($urandom), 16'h2800, 16'hFFFF);
    cmd(16'h0000, 16'h0000, exp_in0(16'h0000, 1'b0, 1'b0), 16'hFDFF);
    for (int k = 0; k < 4; k++) begin
      w = 16'($urandom);
      v = {6'h3F - 6'(k), w[9:0]};
      cmd(v, w, exp_in0(v, 1'b0, 1'b0), 16'hFFFF);
      rd_reg(gptm_pkg::A_IN1, r);
      chk("reply word 2", w, r);
    end
    rd_reg(5'h14, r);
    chk("unmapped read", 16'h0000, r);
    src_check(1'b0);
    cmd(16'h33E0, 16'h0000, 16'h33E0, 16'hFFFF);
    src_check(1'b1);
    cmd(16'h4000, 16'h0003, 16'h4000, 16'hFFFF);
    wr_reg(gptm_pkg::A_OUT1, 16'h0005);
    wr_reg(gptm_pkg::A_OUT0, 16'h4000);
    repeat (30) @(posedge clk);
    rd_reg(gptm_pkg::A_IN1, r);
    chk("repeated preset", 16'h0003, r);
    cmd(16'h1851, 16'h0000, 16'h1851, 16'hFFFF);
    rd_reg(gptm_pkg::A_STAT, r);
    chk("mode flag", 16'h0001, {15'h0000, r[gptm_pkg::STAT_MODE]});
    cmd(16'h0000, 16'h0000, exp_in0(16'h0000, 1'b1, 1'b0), 16'hFC00);
    pulse(3, 1'b0);
    pulse(2, 1'b0);
    pulse(5, 1'b1);
    // settings bit 3 clear: a bus reset must leave the mode alone
    bus_rst();
    repeat (4) @(posedge clk);
    rd_reg(gptm_pkg::A_STAT, r);
    chk("mode after bus reset", 16'h0001, {15'h0000, r[gptm_pkg::STAT_MODE]});
    slow <= 1'b1;
    cmd(16'h4000, 16'h0007, 16'h4000, 16'hFFFF);
    rd_reg(gptm_pkg::A_IN1, r);
    chk("new preset", 16'h0007, r);
    // settings bit 3 set: the same event now drops the mode
    cmd(16'h33E8, 16'h0000, 16'h33E8, 16'hFFFF);
    bus_rst();
    repeat (4) @(posedge clk);
    rd_reg(gptm_pkg::A_STAT, r);
    chk("mode after reacting reset", 16'h0000, {15'h0000, r[gptm_pkg::STAT_MODE]});
    give_verdict();
  end
endmodule

`default_nettype wire
